// ### core/aer_mask_pkg.sv
// Constants for the uncorrectable error mask block
package aer_mask_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] UE_STATUS_OFFSET = 12'h104; // Status register
  localparam logic [11:0] UE_MASK_OFFSET = 12'h108; // Mask register
  localparam logic [11:0] UE_SEVERITY_OFFSET = 12'h10C; // Severity register
  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam logic [31:0] UE_MASK_WRITABLE = 32'h001F3031; // Stored bits
  localparam logic [31:0] UE_STATUS_WRITABLE = 32'h001F3031; // Clearable and severity bits
  localparam logic [31:0] UE_ACTIVE_MASK = 32'h001F3030; // Bit 0 inert
  localparam logic [31:0] UE_MASK_RESET = 32'h00000000; // Mask reset
  localparam logic [31:0] UE_STATUS_RESET = 32'h00000000; // Status reset
  localparam logic [31:0] UE_SEVERITY_RESET = 32'h00062030; // Severity
endpackage

// ### core/aer_uncorrectable_error_mask.sv
// Uncorrectable error mask, status logging and severity selection
`timescale 1ns/100ps
module aer_uncorrectable_error_mask
  import aer_mask_pkg::*;
(
  input wire logic i_clock, // Core clock, 50 MHz
  input wire logic i_srst, // Non-fundamental reset, sticky bits survive
  input wire logic i_fund_srst, // Fundamental reset, returns sticky bits to their reset values
  input wire logic i_clock_enable, // Freezes all state while low and neither reset is asserted
  input wire logic i_cfg_write, // Configuration write strobe
  input wire logic i_cfg_read, // Configuration read strobe
  input wire logic [11:0] i_cfg_addr, // Configuration byte address
  input wire logic [31:0] i_cfg_wdata, // Configuration write data
  input wire logic [3:0] i_cfg_be, // Byte enables
  input wire logic [31:0] i_error_detect, // Per-class detect strobes
  output logic [31:0] o_cfg_rdata, // Read data, one cycle after read
  output logic o_cfg_rvalid, // Read data valid pulse
  output logic [31:0] o_uncorrectable_error_mask, // Mask state
  output logic o_report_fatal, // Fatal error report pulse
  output logic o_report_nonfatal, // Non-fatal error report pulse
  output logic [31:0] o_report_classes // Classes reported this pulse
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] mask; // Mask register
    logic [31:0] status; // Status register
    logic [31:0] severity; // Severity register
    logic [31:0] rdata; // Read data
    logic rvalid; // Read valid
    logic fatal; // Fatal pulse
    logic nonfatal; // Non-fatal pulse
    logic [31:0] classes; // Reported classes
  } state_s;

  state_s state_reg; // Registered state
  state_s state_next; // Next state

  // Expand byte enables to a bit mask
  function automatic logic [31:0] be_bits(input logic [3:0] be);
    be_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  logic [31:0] wr_bits; // Bits selected by byte enables
  logic [31:0] unmasked; // Detected events passing the mask
  logic [31:0] sel_data; // Read mux

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    wr_bits = be_bits(i_cfg_be);
    // Bit 0 never counts toward logging or reporting
    unmasked = i_error_detect & UE_ACTIVE_MASK & ~state_reg.mask;
    // Default pulses low
    state_next.rvalid = 1'b0;
    state_next.fatal = 1'b0;
    state_next.nonfatal = 1'b0;
    state_next.classes = 32'h00000000;
    // Read mux, reserved and hardwired bits read zero
    case (i_cfg_addr)
      UE_STATUS_OFFSET: begin
        sel_data = state_reg.status;
      end
      UE_MASK_OFFSET: begin
        sel_data = state_reg.mask & UE_MASK_WRITABLE;
      end
      UE_SEVERITY_OFFSET: begin
        sel_data = state_reg.severity;
      end
      default: begin
        sel_data = 32'h00000000;
      end
    endcase
    if (i_cfg_read) begin
      state_next.rdata = sel_data;
      state_next.rvalid = 1'b1;
    end
    // Mask write touches only stored bits
    if (i_cfg_write && i_cfg_addr == UE_MASK_OFFSET) begin
      state_next.mask = (state_reg.mask & ~(wr_bits & UE_MASK_WRITABLE))
        | (i_cfg_wdata & wr_bits & UE_MASK_WRITABLE);
    end
    if (i_cfg_write && i_cfg_addr == UE_SEVERITY_OFFSET) begin
      state_next.severity =
        (state_reg.severity & ~(wr_bits & UE_STATUS_WRITABLE))
        | (i_cfg_wdata & wr_bits & UE_STATUS_WRITABLE);
    end
    // Write-one clears, a same-cycle detect wins
    if (i_cfg_write && i_cfg_addr == UE_STATUS_OFFSET) begin
      state_next.status = state_reg.status
        & ~(i_cfg_wdata & wr_bits & UE_STATUS_WRITABLE);
    end
    state_next.status = state_next.status | unmasked;
    // Report only unmasked events, severity picks the class
    if (|unmasked) begin
      state_next.classes = unmasked;
      state_next.fatal = |(unmasked & state_reg.severity);
      state_next.nonfatal = |(unmasked & ~state_reg.severity);
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_fund_srst) begin
      state_reg.mask <= UE_MASK_RESET;
      state_reg.status <= UE_STATUS_RESET;
      state_reg.severity <= UE_SEVERITY_RESET;
      state_reg.rdata <= 32'h00000000;
      state_reg.rvalid <= 1'b0;
      state_reg.fatal <= 1'b0;
      state_reg.nonfatal <= 1'b0;
      state_reg.classes <= 32'h00000000;
    end else if (i_srst) begin
      // Sticky registers hold through a soft reset
      state_reg.rdata <= 32'h00000000;
      state_reg.rvalid <= 1'b0;
      state_reg.fatal <= 1'b0;
      state_reg.nonfatal <= 1'b0;
      state_reg.classes <= 32'h00000000;
    end else if (i_clock_enable) begin
      state_reg <= state_next;
    end
  end

  assign o_cfg_rdata = state_reg.rdata;
  assign o_cfg_rvalid = state_reg.rvalid;
  assign o_uncorrectable_error_mask = state_reg.mask;
  assign o_report_fatal = state_reg.fatal;
  assign o_report_nonfatal = state_reg.nonfatal;
  assign o_report_classes = state_reg.classes;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_masked_not_logged;
    @(posedge i_clock) disable iff (i_srst || i_fund_srst)
    (i_clock_enable && !(i_cfg_write && i_cfg_addr == UE_STATUS_OFFSET))
    |=> ((state_reg.status & ~$past(state_reg.status)
          & $past(state_reg.mask)) == 32'h00000000);
  endproperty
  a_masked_not_logged: assert property (p_masked_not_logged)
    else $error("masked error was logged");

  property p_masked_no_report;
    @(posedge i_clock) disable iff (i_srst || i_fund_srst)
    1'b1 |=> ((o_report_classes & $past(state_reg.mask)) == 32'h00000000);
  endproperty
  a_masked_no_report: assert property (p_masked_no_report)
    else $error("masked error was reported");

  property p_stored_bits;
    @(posedge i_clock) disable iff (i_fund_srst)
    (o_uncorrectable_error_mask & ~UE_MASK_WRITABLE) == 32'h00000000;
  endproperty
  a_stored_bits: assert property (p_stored_bits)
    else $error("mask holds a reserved or hardwired bit");

  property p_mask_write;
    @(posedge i_clock) disable iff (i_srst || i_fund_srst)
    (i_clock_enable && i_cfg_write && i_cfg_addr == UE_MASK_OFFSET
     && i_cfg_be == 4'hF)
    |=> o_uncorrectable_error_mask == ($past(i_cfg_wdata) & UE_MASK_WRITABLE);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_bit0_inert;
    @(posedge i_clock) disable iff (i_srst || i_fund_srst)
    1'b1 |=> !o_report_classes[0];
  endproperty
  a_bit0_inert: assert property (p_bit0_inert)
    else $error("obsolete bit reported");

  property p_detect_sets;
    @(posedge i_clock) disable iff (i_srst || i_fund_srst)
    (i_clock_enable && i_error_detect[4] && !state_reg.mask[4])
    |=> state_reg.status[4];
  endproperty
  a_detect_sets: assert property (p_detect_sets)
    else $error("detected error not logged");

  property p_fatal_sel;
    @(posedge i_clock) disable iff (i_srst || i_fund_srst)
    (i_clock_enable && |(i_error_detect & UE_ACTIVE_MASK & ~state_reg.mask
      & state_reg.severity)) |=> o_report_fatal;
  endproperty
  a_fatal_sel: assert property (p_fatal_sel)
    else $error("fatal report missing");

  property p_soft_reset_keeps;
    @(posedge i_clock)
    (i_srst && !i_fund_srst) |=> $stable(o_uncorrectable_error_mask);
  endproperty
  a_soft_reset_keeps: assert property (p_soft_reset_keeps)
    else $error("mask lost on soft reset");

  // An unmasked class with severity clear must give a non-fatal report
  property p_nonfatal_sel;
    @(posedge i_clock) disable iff (i_srst || i_fund_srst)
    (i_clock_enable && |(i_error_detect & UE_ACTIVE_MASK & ~state_reg.mask
      & ~state_reg.severity)) |=> o_report_nonfatal;
  endproperty
  a_nonfatal_sel: assert property (p_nonfatal_sel)
    else $error("non-fatal report missing");

  // Low clock enable holds every register still
  property p_freeze;
    @(posedge i_clock) disable iff (i_srst || i_fund_srst)
    !i_clock_enable |=> $stable(state_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  c_fatal: cover property (@(posedge i_clock) o_report_fatal);
  c_nonfatal: cover property (@(posedge i_clock) o_report_nonfatal);
  c_mask_write: cover property (@(posedge i_clock)
    i_cfg_write && i_cfg_addr == UE_MASK_OFFSET);
  c_freeze: cover property (@(posedge i_clock)
    !i_clock_enable && |i_error_detect);
endmodule // aer_uncorrectable_error_mask

// ### test/report_sink.sv
// Upstream sink model that counts error report messages
`timescale 1ns/100ps
module report_sink (
  input wire logic i_clock, // Core clock
  input wire logic i_fatal, // Fatal report pulse
  input wire logic i_nonfatal, // Non-fatal report pulse
  output int o_fatal_cnt, // Fatal messages seen
  output int o_nonfatal_cnt // Non-fatal messages seen
);
  // ****************************************************************
  // Message counting
  // ****************************************************************
  // Each one-cycle pulse stands for one message; int counters start at 0
  always @(posedge i_clock) begin
    o_fatal_cnt <= o_fatal_cnt + int'(i_fatal);
    o_nonfatal_cnt <= o_nonfatal_cnt + int'(i_nonfatal);
  end
endmodule // report_sink

// ### test/aer_uncorrectable_error_mask_tb.sv
// Self-checking bench for the uncorrectable error mask block
`timescale 1ns/100ps
module aer_uncorrectable_error_mask_tb;
  import aer_mask_pkg::*;
  // ****************************************************************
  // Signals, design and sink
  // ****************************************************************
  localparam logic [31:0] SEV = 32'h00062030; // Severity after reset
  logic i_clock, i_srst, i_fund_srst, i_cfg_write, i_cfg_read;
  logic [11:0] i_cfg_addr;
  logic [3:0] i_cfg_be, bb;
  logic [31:0] i_cfg_wdata, i_error_detect, o_cfg_rdata, o_report_classes;
  logic [31:0] o_uncorrectable_error_mask, mask_exp, stat_exp, w, sev_exp;
  logic o_cfg_rvalid, o_report_fatal, o_report_nonfatal, cke;
  int error_cnt, cmp_count, seed, fat_n, non_n, fat_cnt, non_cnt, k;
  aer_uncorrectable_error_mask DUT (.i_clock(i_clock), .i_srst(i_srst),
    .i_fund_srst(i_fund_srst), .i_clock_enable(cke),
    .i_cfg_write(i_cfg_write), .i_cfg_read(i_cfg_read),
    .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata),
    .i_cfg_be(i_cfg_be), .i_error_detect(i_error_detect),
    .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
    .o_uncorrectable_error_mask(o_uncorrectable_error_mask),
    .o_report_fatal(o_report_fatal),
    .o_report_nonfatal(o_report_nonfatal),
    .o_report_classes(o_report_classes));
  report_sink sink (.i_clock(i_clock), .i_fatal(o_report_fatal),
    .i_nonfatal(o_report_nonfatal), .o_fatal_cnt(fat_cnt),
    .o_nonfatal_cnt(non_cnt));
  // ****************************************************************
  // Tasks and expectation functions
  // ****************************************************************
  // Lane merge of a mask write, only stored bits survive
  function automatic logic [31:0] merge(input logic [31:0] o, d,
                                        input logic [3:0] b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    return ((o & ~m) | (d & m)) & 32'h001F3031;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    @(posedge i_clock);
    i_cfg_write <= 1'h1;
    i_cfg_addr <= a;
    i_cfg_wdata <= d;
    i_cfg_be <= b;
    @(posedge i_clock);
    i_cfg_write <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clock);
    i_cfg_read <= 1'h1;
    i_cfg_addr <= a;
    @(posedge i_clock);
    i_cfg_read <= 1'h0;
    #1;
    chk("rvalid", 32'h1, {31'h0, o_cfg_rvalid});
    chk("rdata", e, o_cfg_rdata);
  endtask
  // One detect pulse; unmasked live classes log and report
  task automatic det(input logic [31:0] d);
    logic [31:0] a;
    logic f, n;
    // A frozen block takes no detect at all
    a = d & ~mask_exp & 32'h001F3030 & {32{cke}};
    f = |(a & sev_exp);
    n = |(a & ~sev_exp);
    @(posedge i_clock);
    i_error_detect <= d;
    @(posedge i_clock);
    i_error_detect <= 32'h0;
    #1;
    stat_exp = stat_exp | a;
    fat_n += int'(f);
    non_n += int'(n);
    chk("fatal", {31'h0, f}, {31'h0, o_report_fatal});
    chk("nonfatal", {31'h0, n}, {31'h0, o_report_nonfatal});
    chk("classes", a, o_report_classes);
  endtask
  task automatic test_done;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    i_clock = 1'h0;
    forever #10 i_clock = ~i_clock;
  end
  // Cuts a hang short
  initial begin
    #400000;
    error_cnt++;
    test_done;
  end
  initial begin
    {error_cnt, cmp_count, fat_n, non_n, mask_exp, stat_exp} = '0;
    {i_cfg_write, i_cfg_read, i_cfg_addr, i_cfg_be} = '0;
    {i_cfg_wdata, i_error_detect} = '0;
    seed = 28097;
    sev_exp = SEV;
    cke = 1'h1;
    i_srst = 1'h1;
    i_fund_srst = 1'h1;
    repeat (12) @(posedge i_clock);
    i_srst <= 1'h0;
    i_fund_srst <= 1'h0;
    rd(UE_MASK_OFFSET, 32'h0);
    rd(UE_SEVERITY_OFFSET, SEV);
    rd(12'h200, 32'h0);
    wr(UE_MASK_OFFSET, 32'hFFFFFFFF, 4'hF);
    mask_exp = 32'h001F3031;
    rd(UE_MASK_OFFSET, mask_exp);
    det(32'hFFFFFFFF);
    rd(UE_STATUS_OFFSET, 32'h0);
    for (k = 0; k < 40; k++) begin
      bb = 4'($random(seed));
      w = $random(seed);
      wr(UE_MASK_OFFSET, w, bb);
      mask_exp = merge(mask_exp, w, bb);
      #1;
      chk("mask", mask_exp, o_uncorrectable_error_mask);
      det($random(seed));
    end
    rd(UE_STATUS_OFFSET, stat_exp);
    wr(UE_MASK_OFFSET, 32'h0, 4'hF);
    mask_exp = 32'h0;
    w = $random(seed);
    wr(UE_SEVERITY_OFFSET, w, 4'hF);
    sev_exp = merge(sev_exp, w, 4'hF);
    rd(UE_SEVERITY_OFFSET, sev_exp);
    for (k = 0; k < 21; k++) det(32'h1 << k);
    wr(UE_STATUS_OFFSET, 32'hFFFFFFFF, 4'hF);
    stat_exp = 32'h0;
    rd(UE_STATUS_OFFSET, stat_exp);
    // Clock enable low: neither a write nor a detect may land
    @(posedge i_clock);
    cke <= 1'h0;
    wr(UE_MASK_OFFSET, 32'h001F3031, 4'hF);
    det(32'h00000010);
    @(posedge i_clock);
    cke <= 1'h1;
    #1;
    chk("frozen mask", mask_exp, o_uncorrectable_error_mask);
    rd(UE_STATUS_OFFSET, stat_exp);
    wr(UE_MASK_OFFSET, 32'hFFFF1234, 4'h5);
    mask_exp = 32'h001F0030;
    @(posedge i_clock);
    i_srst <= 1'h1;
    @(posedge i_clock);
    i_srst <= 1'h0;
    rd(UE_MASK_OFFSET, mask_exp);
    rd(UE_SEVERITY_OFFSET, sev_exp);
    @(posedge i_clock);
    i_fund_srst <= 1'h1;
    @(posedge i_clock);
    i_fund_srst <= 1'h0;
    rd(UE_MASK_OFFSET, 32'h0);
    rd(UE_SEVERITY_OFFSET, SEV);
    chk("fatal count", 32'(fat_n), 32'(fat_cnt));
    chk("nonfatal count", 32'(non_n), 32'(non_cnt));
    test_done;
  end
endmodule // aer_uncorrectable_error_mask_tb
